// [hdl/cpu_control_instruction_unit.sv]
// Control-instruction execution unit of an 8-bit register-oriented CPU.

`timescale 1ns/1ps
`default_nettype none

module cpu_control_instruction_unit (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Mode and interrupt pins, asynchronous to ref_clk.
    input wire logic clearN,
    input wire logic waitN,
    input wire logic intReqN,
    // External memory; read data is valid the cycle after rd is seen.
    output cpu_ctrl_pkg::mem_req_t memReq,
    input wire logic [7:0] memRdata,
    // Output-port transfers.
    output cpu_ctrl_pkg::io_out_t ioOut,
    // Status pins.
    output logic flagOut,
    output logic [3:0] progSel,
    output logic [3:0] dataSel,
    output logic intEnable
);
    // ------------------------------------------------------------
    // State and storage.
    // ------------------------------------------------------------
    typedef enum logic [2:0] {FETCH, FWAIT, DECODE, XWAIT, XDATA, XWRITE} state_t;
    state_t state_r;
    // Two-flop synchronisers for the pins.
    logic [1:0] clearSync_r, waitSync_r, intSync_r;
    // Designators, temporary byte and the flag.
    logic [3:0] pSel_r, xSel_r;
    logic [7:0] tmp_r;
    logic [7:0] opcode_r;
    logic flag_r, ie_r, first_r;
    cpu_ctrl_pkg::mem_req_t memReq_r;
    cpu_ctrl_pkg::io_out_t ioOut_r;

    // Synchronisers: the first stage feeds only the second.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clearSync_r <= 2'h0;
            waitSync_r <= 2'h3;
            intSync_r <= 2'h3;
        end else begin
            clearSync_r <= {clearSync_r[0], clearN};
            waitSync_r <= {waitSync_r[0], waitN};
            intSync_r <= {intSync_r[0], intReqN};
        end
    end

    // ------------------------------------------------------------
    // Decode of modes and the current byte.
    // ------------------------------------------------------------
    // Reset mode is clear low with wait high; both high means run.
    wire resetMode = !clearSync_r[1] && waitSync_r[1];
    wire cpuRst = srst || resetMode;
    wire running = clearSync_r[1] && waitSync_r[1];
    wire intPending = !intSync_r[1];
    // The opcode is decoded straight off the bus in DECODE, from the latch later.
    wire [7:0] op = (state_r == DECODE) ? memRdata : opcode_r;
    wire isSelPc = op[7:4] == cpu_ctrl_pkg::OP_SEL_PC_HI;
    wire isSelDp = op[7:4] == cpu_ctrl_pkg::OP_SEL_DP_HI;
    wire isOut = op[7:3] == cpu_ctrl_pkg::OP_OUT_HI && op[2:0] != cpu_ctrl_pkg::OP_OUT_NONE;
    wire isRestore = op == cpu_ctrl_pkg::OP_RESTORE_EN || op == cpu_ctrl_pkg::OP_RESTORE_MASK;
    wire isBranch = op == cpu_ctrl_pkg::OP_BR_FLAG_HIGH || op == cpu_ctrl_pkg::OP_BR_FLAG_LOW;
    wire isPush = op == cpu_ctrl_pkg::OP_PUSH_STATUS;
    wire isMark = op == cpu_ctrl_pkg::OP_MARK;
    wire xInc = isOut || isRestore;
    wire brTaken = (op == cpu_ctrl_pkg::OP_BR_FLAG_HIGH && flag_r)
                || (op == cpu_ctrl_pkg::OP_BR_FLAG_LOW && !flag_r);
    // Interrupt gated off during the first instruction.
    wire intTake = state_r == FETCH && running && ie_r && !first_r && intPending;
    wire [7:0] statusByte = {xSel_r, pSel_r};

    // ------------------------------------------------------------
    // Register-file ports.
    // ------------------------------------------------------------
    logic [15:0] rpVal, rxVal;
    // Mark addresses the stack register; everything else uses the data pointer.
    wire [3:0] idxB = (state_r == DECODE && isMark) ? cpu_ctrl_pkg::STACK_IDX : xSel_r;
    wire fetchInc = state_r == FETCH && running && !intTake;
    wire decInc = state_r == DECODE && (xInc || isBranch || isMark);
    wire brLoad = state_r == XDATA && isBranch && brTaken;
    wire wrEn = fetchInc || decInc || brLoad;
    // Decode-cycle increment of the data-pointer register, or decrement of the stack register for mark.
    // When indices match, this follows the fetch increment of the same entry.
    wire [3:0] wrIdx = (decInc && !isBranch) ? idxB : pSel_r;
    wire [15:0] wrData = brLoad ? {rpVal[15:8], memRdata}
                       : (decInc && isMark) ? rxVal - cpu_ctrl_pkg::ONE16
                       : (decInc && !isBranch) ? rxVal + cpu_ctrl_pkg::ONE16
                       : rpVal + cpu_ctrl_pkg::ONE16;

    scratchpad_regs i_scratchpad_regs (
        .ref_clk(ref_clk),
        .srst(srst),
        .wrEn(wrEn),
        .wrIdx(wrIdx),
        .wrData(wrData),
        .rdIdxA(pSel_r),
        .rdIdxB(idxB),
        .rdDataA(rpVal),
        .rdDataB(rxVal)
    );

    // ------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------
    // Only FETCH honours wait, so an instruction in flight always completes.
    always_ff @(posedge ref_clk) begin
        if (cpuRst) begin
            state_r <= FETCH;
            opcode_r <= cpu_ctrl_pkg::OP_NOP;
        end else begin
            case (state_r)
                FETCH: begin
                    if (fetchInc) begin
                        state_r <= FWAIT;
                    end
                end
                FWAIT: state_r <= DECODE;
                DECODE: begin
                    opcode_r <= memRdata;
                    if (xInc || isBranch) begin
                        state_r <= XWAIT;
                    end else if (isPush || isMark) begin
                        state_r <= XWRITE;
                    end else begin
                        // Any other byte just returns to fetch.
                        state_r <= FETCH;
                    end
                end
                XWAIT: state_r <= XDATA;
                XDATA: state_r <= FETCH;
                XWRITE: state_r <= FETCH;
                default: state_r <= FETCH;
            endcase
        end
    end

    // Memory and output-port strobes; pulses fall back each cycle.
    always_ff @(posedge ref_clk) begin
        if (cpuRst) begin
            memReq_r <= '0;
            ioOut_r <= '0;
        end else begin
            memReq_r.rd <= 1'b0;
            memReq_r.wr <= 1'b0;
            ioOut_r.strobe <= 1'b0;
            if (fetchInc) begin
                memReq_r.addr <= rpVal;
                memReq_r.rd <= 1'b1;
            end else if (state_r == DECODE && (xInc || isBranch)) begin
                memReq_r.addr <= isBranch ? rpVal : rxVal;
                memReq_r.rd <= 1'b1;
            end else if (state_r == DECODE && isPush) begin
                // Push the temporary byte at the data pointer.
                memReq_r.addr <= rxVal;
                memReq_r.wr <= 1'b1;
                memReq_r.wdata <= tmp_r;
            end else if (state_r == DECODE && isMark) begin
                // Mark stores the live designators at the stack.
                memReq_r.addr <= rxVal;
                memReq_r.wr <= 1'b1;
                memReq_r.wdata <= statusByte;
            end
            if (state_r == XDATA && isOut) begin
                ioOut_r.strobe <= 1'b1;
                ioOut_r.sel <= op[2:0];
                ioOut_r.data <= memRdata;
            end
        end
    end

    // Designators, temporary byte, interrupt enable and first-instruction mark.
    always_ff @(posedge ref_clk) begin
        if (cpuRst) begin
            pSel_r <= cpu_ctrl_pkg::SEL_RESET;
            xSel_r <= cpu_ctrl_pkg::SEL_RESET;
            tmp_r <= 8'h00;
            ie_r <= 1'b1;
            first_r <= 1'b1;
        end else if (intTake) begin
            // Save designators, vector to the interrupt counter.
            tmp_r <= statusByte;
            xSel_r <= cpu_ctrl_pkg::STACK_IDX;
            pSel_r <= cpu_ctrl_pkg::INT_PC_IDX;
            ie_r <= 1'b0;
        end else if (state_r == DECODE) begin
            first_r <= 1'b0;
            if (isSelPc) begin
                pSel_r <= memRdata[3:0];
            end
            if (isSelDp) begin
                xSel_r <= memRdata[3:0];
            end
            if (isMark) begin
                tmp_r <= statusByte;
                xSel_r <= pSel_r;
            end
        end else if (state_r == XDATA && isRestore) begin
            // Restore both designators from the byte at the data pointer.
            xSel_r <= memRdata[cpu_ctrl_pkg::DP_FIELD_LSB +: 4];
            pSel_r <= memRdata[cpu_ctrl_pkg::PC_FIELD_LSB +: 4];
            // Enable or mask interrupts by opcode.
            ie_r <= op == cpu_ctrl_pkg::OP_RESTORE_EN;
        end
    end

    // Flag flip-flop; reset mode holds it low.
    always_ff @(posedge ref_clk) begin
        if (cpuRst) begin
            flag_r <= 1'b0;
        end else if (state_r == DECODE && memRdata == cpu_ctrl_pkg::OP_SET_FLAG) begin
            // Set and clear of the flag.
            flag_r <= 1'b1;
        end else if (state_r == DECODE && memRdata == cpu_ctrl_pkg::OP_CLR_FLAG) begin
            flag_r <= 1'b0;
        end
    end
    assign memReq = memReq_r;
    assign ioOut = ioOut_r;
    assign flagOut = flag_r;
    assign progSel = pSel_r;
    assign dataSel = xSel_r;
    assign intEnable = ie_r;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (cpuRst);
    sequence s_decode_xinc_same;
        state_r == DECODE && xInc && xSel_r == pSel_r;
    endsequence
    chk_nop_pc_only: assert property (state_r == DECODE && memRdata == cpu_ctrl_pkg::OP_NOP
        |=> state_r == FETCH && $stable(flag_r) && $stable(xSel_r) && $stable(ie_r) && $stable(pSel_r))
        else $error("no-operation changed more than the counter");
    chk_pc_select: assert property (state_r == DECODE && isSelPc
        |=> pSel_r == $past(memRdata[3:0]))
        else $error("program-counter select not loaded");
    chk_dp_select: assert property (state_r == DECODE && isSelDp
        |=> xSel_r == $past(memRdata[3:0]))
        else $error("data-pointer select not loaded");
    chk_double_inc: assert property (s_decode_xinc_same
        |=> memReq.addr == $past(memReq.addr) + cpu_ctrl_pkg::ONE16 && memReq.rd)
        else $error("operand not taken from the byte after the opcode");
    chk_flag_set: assert property (state_r == DECODE && memRdata == cpu_ctrl_pkg::OP_SET_FLAG
        |=> flagOut ##1 flagOut)
        else $error("flag not set");
    chk_branch_high: assert property (state_r == XDATA && op == cpu_ctrl_pkg::OP_BR_FLAG_HIGH
        && flag_r |=> rpVal[7:0] == $past(memRdata) && state_r == FETCH)
        else $error("taken branch did not load the target");
    chk_flag_reset: assert property (@(posedge ref_clk) disable iff (srst)
        resetMode |=> !flagOut)
        else $error("flag not cleared in reset mode");
    chk_int_save: assert property (intTake
        |=> tmp_r == $past(statusByte) && pSel_r == cpu_ctrl_pkg::INT_PC_IDX && !ie_r)
        else $error("interrupt did not save designators");
    chk_push_byte: assert property (state_r == DECODE && isPush
        |=> memReq.wr && memReq.wdata == $past(tmp_r) && memReq.addr == $past(rxVal))
        else $error("push wrote the wrong byte");
    chk_mark_byte: assert property (state_r == DECODE && isMark
        |=> memReq.wr && memReq.wdata == $past(statusByte))
        else $error("mark wrote the wrong byte");
    chk_restore_regs: assert property (state_r == XDATA && isRestore
        |=> {xSel_r, pSel_r} == $past(memRdata) && state_r == FETCH)
        else $error("return did not restore designators");
    chk_restore_ie: assert property (state_r == XDATA && op == cpu_ctrl_pkg::OP_RESTORE_MASK
        |=> !ie_r)
        else $error("masking return left interrupts enabled");
    chk_first_no_int: assert property (state_r == FETCH && first_r |=> $stable(ie_r)
        && $stable(pSel_r)) else $error("interrupt taken during first instruction");
endmodule // cpu_control_instruction_unit
`default_nettype wire

// [hdl/scratchpad_regs.sv]
// Shared constants and carriers, plus the sixteen-entry scratch-pad register file.
`timescale 1ns/1ps
`default_nettype none

package cpu_ctrl_pkg;
    // ------------------------------------------------------------
    // Opcodes handled by the control-instruction unit.
    // ------------------------------------------------------------
    localparam logic [7:0] OP_NOP = 8'hc4;
    localparam logic [3:0] OP_SEL_PC_HI = 4'hd;
    localparam logic [3:0] OP_SEL_DP_HI = 4'he;
    localparam logic [7:0] OP_SET_FLAG = 8'h7b;
    localparam logic [7:0] OP_CLR_FLAG = 8'h7a;
    localparam logic [7:0] OP_PUSH_STATUS = 8'h78;
    localparam logic [7:0] OP_MARK = 8'h79;
    localparam logic [7:0] OP_RESTORE_EN = 8'h70;
    localparam logic [7:0] OP_RESTORE_MASK = 8'h71;
    localparam logic [4:0] OP_OUT_HI = 5'h0c;
    localparam logic [2:0] OP_OUT_NONE = 3'h0;
    localparam logic [7:0] OP_BR_FLAG_HIGH = 8'h31;
    localparam logic [7:0] OP_BR_FLAG_LOW = 8'h39;
    // ------------------------------------------------------------
    // Fixed register indices and reset values.
    // ------------------------------------------------------------
    localparam logic [3:0] STACK_IDX = 4'h2;
    localparam logic [3:0] INT_PC_IDX = 4'h1;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam int NUM_REGS = 16;
    // Packed byte layout of the saved designators: data pointer high nibble.
    localparam int DP_FIELD_LSB = 4;
    localparam int PC_FIELD_LSB = 0;

    // One request to external memory; rd and wr are one-cycle pulses.
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } mem_req_t;

    // One output-port transfer; strobe is a one-cycle pulse.
    typedef struct packed {
        logic strobe;
        logic [2:0] sel;
        logic [7:0] data;
    } io_out_t;
endpackage

module scratchpad_regs (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Single write port.
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [15:0] wrData,
    // Two combinational read ports.
    input wire logic [3:0] rdIdxA,
    input wire logic [3:0] rdIdxB,
    output logic [15:0] rdDataA,
    output logic [15:0] rdDataB
);
    // Storage is plain flip-flops, one 16-bit word per entry.
    logic [15:0] regs [cpu_ctrl_pkg::NUM_REGS];

    // ------------------------------------------------------------
    // Per-entry storage.
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < cpu_ctrl_pkg::NUM_REGS; i++) begin : g_entry
            // Each entry loads only when the write index selects it.
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    regs[i] <= cpu_ctrl_pkg::REG_RESET;
                end else if (wrEn && wrIdx == 4'(i)) begin
                    regs[i] <= wrData;
                end
            end
        end
    endgenerate

    // Reads are combinational so a fetch sees the pointer with no extra cycle.
    assign rdDataA = regs[rdIdxA];
    assign rdDataB = regs[rdIdxB];
endmodule // scratchpad_regs

`default_nettype wire

// [verification/program_memory_model.sv]
// Behavioural external program and data memory for the control-instruction unit.
`timescale 1ns/1ps
`default_nettype none

module program_memory_model (
    // Clock.
    input wire logic ref_clk,
    // Requests from the device.
    input wire cpu_ctrl_pkg::mem_req_t memReq,
    // Read data back to the device.
    output logic [7:0] memRdata
);
    // ------------------------------------------------------------
    // Storage and read pipeline.
    // ------------------------------------------------------------
    // Only the low address byte selects a cell, so the stack at 16'hffff lands in cell 8'hff.
    logic [7:0] mem [0:255];
    // Byte taken on the last read pulse.
    logic [7:0] readByte_r;
    // High in the one cycle where read data is valid.
    logic readValid_r;

    // Reads answer one cycle after the pulse; writes land on their pulse.
    always @(posedge ref_clk) begin
        readValid_r <= memReq.rd;
        if (memReq.rd) begin
            readByte_r <= mem[memReq.addr[7:0]];
        end
        if (memReq.wr) begin
            mem[memReq.addr[7:0]] <= memReq.wdata;
        end
    end

    // Outside the valid cycle the bus shows the inverse, so a late sample never looks right.
    assign memRdata = readValid_r ? readByte_r : ~readByte_r;
endmodule // program_memory_model
`default_nettype wire

// [verification/test_cpu_control_instruction_unit.sv]
// Self-checking testbench running a short control-instruction program.
`timescale 1ns/1ps
`default_nettype none

module test_cpu_control_instruction_unit;
    // ------------------------------------------------------------
    // Signals.
    // ------------------------------------------------------------
    logic ref_clk = 1'b0; // 100 MHz clock.
    logic srst = 1'b1; // Synchronous reset.
    logic clearN = 1'b1; // Clear pin.
    logic waitN = 1'b1; // Wait pin.
    logic intReqN = 1'b0; // Held low from the start so the first instruction is tested.
    cpu_ctrl_pkg::mem_req_t memReq;
    logic [7:0] memRdata;
    cpu_ctrl_pkg::io_out_t ioOut;
    logic flagOut;
    logic [3:0] progSel;
    logic [3:0] dataSel;
    logic intEnable;
    int errors = 0; // Mismatches.
    int checksDone = 0; // Comparisons.
    // Program from address 0, byte n in bits 8n+7:8n: mask, pointer, flag, branches, output,
    // a low branch over a set, mark, restore, park.
    localparam logic [183:0] PROG = 184'h15317b60_7079e57b_10397a5a_61e02039_7a07317b_e30071;

    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Device and memory.
    // ------------------------------------------------------------
    cpu_control_instruction_unit i_cpu_control_instruction_unit (
        .ref_clk(ref_clk), .srst(srst), .clearN(clearN), .waitN(waitN), .intReqN(intReqN),
        .memReq(memReq), .memRdata(memRdata), .ioOut(ioOut), .flagOut(flagOut),
        .progSel(progSel), .dataSel(dataSel), .intEnable(intEnable)
    );
    program_memory_model i_program_memory_model (
        .ref_clk(ref_clk), .memReq(memReq), .memRdata(memRdata)
    );

    // ------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------
    // Compares one value and counts it.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Evaluates one of the milestones the program passes.
    function automatic logic reached(input int code);
        case (code)
            0: return dataSel === 4'h3;
            1: return flagOut === 1'b1;
            2: return ioOut.strobe === 1'b1;
            3: return flagOut === 1'b0;
            4: return memReq.wr === 1'b1;
            5: return intEnable === 1'b1;
            6: return progSel === 4'h1;
            default: return progSel === 4'h0;
        endcase
    endfunction

    // Steps the clock until a milestone shows; a missing one is a mismatch.
    task automatic step_until(input int code);
        int n;
        n = 0;
        while (!reached(code) && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            errors++;
            $display("Error at %0t ns: milestone %0d missing, seen %h expected %h", $time, code,
                1'b0, 1'b1);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        for (int a = 0; a < 256; a++) begin
            i_program_memory_model.mem[a] = (a < 23) ? PROG[8 * a +: 8] : 8'h00;
        end
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        // Pending interrupt must not be taken before the masking return runs.
        step_until(0);
        check(progSel, 16'h0000); // no interrupt taken
        check(intEnable, 16'h0000); // masking return
        check(dataSel, 16'h0003); // pointer select
        // Drop the request well before the enabling return, or it would fire at once.
        @(posedge ref_clk);
        intReqN <= 1'b1;
        step_until(1);
        check(flagOut, 16'h0001); // flag set
        // The skipped clear keeps the flag high; the untaken low branch reaches the output.
        step_until(2);
        check(ioOut.sel, 16'h0001); // output port
        check(ioOut.data, 16'h005a); // operand after opcode
        check(flagOut, 16'h0001); // branch on flag high
        step_until(3);
        check(flagOut, 16'h0000); // flag cleared
        // The taken low branch hops over a set, so the flag is still low at the mark.
        step_until(4);
        check(flagOut, 16'h0000); // branch on flag low
        check(memReq.addr, 16'h0000); // mark at stack
        check(memReq.wdata, 16'h0050); // designator packing
        step_until(5);
        check(dataSel, 16'h0006); // restored pointer
        check(progSel, 16'h0000); // restored counter
        // Park loop reached; the service routine pushes, idles once and hands back to R0.
        step_until(1);
        i_program_memory_model.mem[0] = 8'h78;
        i_program_memory_model.mem[1] = 8'hc4;
        i_program_memory_model.mem[2] = 8'hd0;
        @(posedge ref_clk);
        intReqN <= 1'b0;
        step_until(6);
        check(dataSel, 16'h0002); // interrupt designators
        check(intEnable, 16'h0000); // interrupt masks
        step_until(4);
        check(memReq.addr, 16'hffff); // push at stack
        check(memReq.wdata, 16'h0060); // saved byte
        step_until(7);
        check(progSel, 16'h0000); // counter select
        // Reset mode forces the flag low.
        @(posedge ref_clk);
        clearN <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        check(flagOut, 16'h0000); // reset mode flag
        check(intEnable, 16'h0001); // reset mode state
        give_verdict();
    end

    // Watchdog: the whole program needs about a hundred cycles.
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule // test_cpu_control_instruction_unit
`default_nettype wire
